/* File: eil_pkg.sv */
// Package for the external interrupt latch: register map, field positions, reset values and vector addresses.
// Assumes a byte-wide register port with one-cycle strobes and read data one cycle later.
package eil_pkg;

  // Register offsets on the plain register port.
  localparam logic [1:0] EIL_STATUS_CONTROL_OFS = 2'h0;
  localparam logic [1:0] EIL_BREAK_FLAG_CTL_OFS = 2'h1;

  // Field positions in the status and control register.
  localparam int EIL_SENS_BIT    = 0;
  localparam int EIL_MASK_BIT    = 1;
  localparam int EIL_ACK_BIT     = 2;
  localparam int EIL_PENDING_BIT = 3;

  // Field position in the break flag control register.
  localparam int EIL_BREAK_CLEAR_ENABLE_BIT = 7;

  // Reset values.
  localparam logic       EIL_SENS_RST = 1'b0;
  localparam logic       EIL_MASK_RST = 1'b0;
  localparam logic       EIL_BREAK_CLEAR_ENABLE_RST = 1'b0;
  localparam logic [7:0] EIL_RDATA_RST = 8'h00;

  // Vector pair fetched for this request.
  localparam logic [15:0] EIL_VECTOR_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] EIL_VECTOR_LO_ADDR = 16'hFFFB;

  // Synchroniser depth on the pin.
  localparam int EIL_SYNC_STAGES = 2;

  // Sensitivity selection.
  typedef enum logic {EIL_EDGE_ONLY, EIL_EDGE_LEVEL} eil_sens_e;

endpackage

/* File: eil_pin_if.sv */
// Interface carrying the synchronised pin level and its falling-edge event between the modules.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface eil_pin_if;
  logic pin_level;
  logic pin_fall;

  modport src
  (
    output pin_level,
    output pin_fall
  );
  modport dst
  (
    input  pin_level,
    input  pin_fall
  );
endinterface

/* File: eil_pin_sync.sv */
// Two-stage synchroniser and falling-edge detector for the active-low interrupt pin.
// Assumes the pin is asynchronous to core_clk_i and idles high through its pullup.
`timescale 1ns/1ps
module eil_pin_sync
  import eil_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // Raw pin.
  input  wire logic irq_n_i,
  // Synchronised view.
  eil_pin_if.src    pin
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic [2:0] arm_ff;

  // Two flops before any logic; the first stage feeds only the second.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= irq_n_i;
      sync2_ff <= sync1_ff;
    end
  end

  // Previous level for edge detection; reset high to match the idle pin.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prev_ff <= 1'b1;
    else
      prev_ff <= sync2_ff;
  end

  // Arming shift: a pin held low through reset would look like a fresh fall once the
  // reset-high synchroniser refills, and would re-latch the request that reset removed.
  // The trade-off is that a pin already low when first sampled never counts as an edge.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      arm_ff <= 3'h0;
    else
      arm_ff <= {arm_ff[1:0], 1'b1};
  end

  // Level and one-cycle falling-edge pulse.
  assign pin.pin_level = sync2_ff;
  assign pin.pin_fall  = arm_ff[2] & prev_ff & ~sync2_ff;

endmodule

/* File: eil_ext_irq.sv */
// External interrupt latch: pin latch, acknowledge, mask, sensitivity and break handling.
// Assumes the CPU gives a one-cycle vector-fetch pulse and levels for break state and the global mask.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module eil_ext_irq
  import eil_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // External pin, active low.
  input  wire logic        irq_n_i,
  // Register port.
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // CPU side.
  input  wire logic        vector_fetch_i,
  input  wire logic        break_state_i,
  input  wire logic        ccr_int_mask_i,
  output logic             cpu_irq_req_o,
  output logic [15:0]      vector_hi_addr_o,
  output logic [15:0]      vector_lo_addr_o,
  output logic             pin_level_o
);

  eil_pin_if pin_bus ();

  logic sens_ff;
  logic mask_ff;
  logic break_clear_enable_ff;
  logic latch_ff;
  logic [7:0] rdata_ff;
  logic sw_ack;
  logic ack;
  logic pending;

  // Pin synchroniser and edge detector.
  eil_pin_sync u_sync
  (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .irq_n_i    (irq_n_i),
    .pin        (pin_bus.src)
  );

  // Software acknowledge is blocked during break unless break clear is enabled.
  assign sw_ack = reg_wr_i && (reg_addr_i == EIL_STATUS_CONTROL_OFS) && reg_wdata_i[EIL_ACK_BIT]
                  && (!break_state_i || break_clear_enable_ff);
  assign ack    = sw_ack || vector_fetch_i;

  // Control bits, cleared by reset.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sens_ff <= EIL_SENS_RST;
      mask_ff <= EIL_MASK_RST;
    end
    else if (reg_wr_i && reg_addr_i == EIL_STATUS_CONTROL_OFS)
    begin
      sens_ff <= reg_wdata_i[EIL_SENS_BIT];
      mask_ff <= reg_wdata_i[EIL_MASK_BIT];
    end
  end

  // Break clear-enable, default zero to protect flags in break.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      break_clear_enable_ff <= EIL_BREAK_CLEAR_ENABLE_RST;
    else if (reg_wr_i && reg_addr_i == EIL_BREAK_FLAG_CTL_OFS)
      break_clear_enable_ff <= reg_wdata_i[EIL_BREAK_CLEAR_ENABLE_BIT];
  end

  // Latch: a new edge wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      latch_ff <= 1'b0;
    else if (pin_bus.pin_fall)
      latch_ff <= 1'b1;
    else if (ack)
      latch_ff <= 1'b0;
  end

  // In level mode a low pin keeps the request pending after the acknowledge.
  assign pending = latch_ff || (sens_ff && !pin_bus.pin_level);

  // Masks gate the request; the pending flag ignores them.
  assign cpu_irq_req_o    = pending && !mask_ff && !ccr_int_mask_i;
  assign vector_hi_addr_o = EIL_VECTOR_HI_ADDR;
  assign vector_lo_addr_o = EIL_VECTOR_LO_ADDR;
  assign pin_level_o      = pin_bus.pin_level;

  // Read data, valid the cycle after the strobe; acknowledge reads zero.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_ff <= EIL_RDATA_RST;
    else if (reg_rd_i)
    begin
      rdata_ff <= 8'h00;
      if (reg_addr_i == EIL_STATUS_CONTROL_OFS)
      begin
        rdata_ff[EIL_SENS_BIT]    <= sens_ff;
        rdata_ff[EIL_MASK_BIT]    <= mask_ff;
        rdata_ff[EIL_PENDING_BIT] <= pending;
      end
      else if (reg_addr_i == EIL_BREAK_FLAG_CTL_OFS)
        rdata_ff[EIL_BREAK_CLEAR_ENABLE_BIT] <= break_clear_enable_ff;
    end
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata_o = rdata_ff;

  // Assertions.
  // They watch the latch and the register port from inside, so a fault shows up at the
  // edge where it happens rather than at the next bench readback.
  property p_fall_sets;
    @(posedge core_clk_i) disable iff (!rstn_i) pin_bus.pin_fall |=> latch_ff;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("edge did not set latch");

  property p_fetch_clears;
    @(posedge core_clk_i) disable iff (!rstn_i) vector_fetch_i && !pin_bus.pin_fall |=> !latch_ff;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears) else $error("fetch did not clear latch");

  property p_break_protect;
    @(posedge core_clk_i) disable iff (!rstn_i)
      latch_ff && break_state_i && !break_clear_enable_ff && !vector_fetch_i |=> latch_ff;
  endproperty
  a_break_protect: assert property (p_break_protect) else $error("break ack changed latch");

  property p_mask_blocks;
    @(posedge core_clk_i) disable iff (!rstn_i) (mask_ff || ccr_int_mask_i) |-> !cpu_irq_req_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked request forwarded");

  property p_level_hold;
    @(posedge core_clk_i) disable iff (!rstn_i) sens_ff && !pin_bus.pin_level |-> pending;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level request dropped");

  property p_edge_only_clear;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !sens_ff && ack && !pin_bus.pin_fall ##1 !sens_ff |-> !pending;
  endproperty
  a_edge_only_clear: assert property (p_edge_only_clear) else $error("edge ack not immediate");

  property p_rd_pending;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == EIL_STATUS_CONTROL_OFS |=> reg_rdata_o[EIL_PENDING_BIT] == $past(pending)
      && !reg_rdata_o[EIL_ACK_BIT];
  endproperty
  a_rd_pending: assert property (p_rd_pending) else $error("status readback wrong");

  property p_sync_delay;
    @(posedge core_clk_i) disable iff (!rstn_i)
      $past(rstn_i) && $past(rstn_i, 2) |-> pin_level_o == $past(irq_n_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin level not two-stage");

  // Step events for the properties below, each used by one of them: an acknowledge that no new edge overrides,
  // and the pin standing high again in level mode.
  sequence s_clean_ack;
    ack && !pin_bus.pin_fall;
  endsequence

  sequence s_clean_sw_ack;
    sw_ack && !pin_bus.pin_fall;
  endsequence

  sequence s_level_ack;
    sens_ff && ack && !pin_bus.pin_fall;
  endsequence

  sequence s_level_pin_high;
    sens_ff && pin_bus.pin_level;
  endsequence

  sequence s_break_sw_ack;
    break_state_i && break_clear_enable_ff && sw_ack && !pin_bus.pin_fall;
  endsequence

  // A software acknowledge that no edge overrides empties the latch on the next edge.
  property p_sw_ack_clears;
    @(posedge core_clk_i) disable iff (!rstn_i) s_clean_sw_ack |=> !latch_ff;
  endproperty
  a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("software ack did not clear latch");

  // Without an acknowledge the latch holds whatever the pin does.
  property p_edge_hold;
    @(posedge core_clk_i) disable iff (!rstn_i) latch_ff && !ack |=> latch_ff;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("latch dropped without ack");

  // Only a falling edge may set the latch.
  property p_no_self_set;
    @(posedge core_clk_i) disable iff (!rstn_i) !latch_ff && !pin_bus.pin_fall |=> !latch_ff;
  endproperty
  a_no_self_set: assert property (p_no_self_set) else $error("latch set without edge");

  // Level mode: once acknowledged and the pin is back high, nothing stays pending.
  property p_level_release;
    @(posedge core_clk_i) disable iff (!rstn_i) s_level_ack ##1 s_level_pin_high |-> !pending;
  endproperty
  a_level_release: assert property (p_level_release) else $error("level request not released");

  // A fresh edge after an acknowledge latches again.
  property p_rearm;
    @(posedge core_clk_i) disable iff (!rstn_i) s_clean_ack ##1 pin_bus.pin_fall |=> latch_ff;
  endproperty
  a_rearm: assert property (p_rearm) else $error("edge after ack lost");

  // An unmasked pending request reaches the priority logic.
  property p_req_forward;
    @(posedge core_clk_i) disable iff (!rstn_i) pending && !mask_ff && !ccr_int_mask_i |-> cpu_irq_req_o;
  endproperty
  a_req_forward: assert property (p_req_forward) else $error("unmasked request withheld");

  // The global mask alone is enough to block the request.
  property p_ccr_blocks;
    @(posedge core_clk_i) disable iff (!rstn_i) ccr_int_mask_i && pending |-> !cpu_irq_req_o;
  endproperty
  a_ccr_blocks: assert property (p_ccr_blocks) else $error("global mask ignored");

  // The pending flag reads one even while the module mask hides the request.
  property p_rd_pending_masked;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == EIL_STATUS_CONTROL_OFS && mask_ff && pending |=> reg_rdata_o[EIL_PENDING_BIT];
  endproperty
  a_rd_pending_masked: assert property (p_rd_pending_masked) else $error("masked pending unreadable");

  // The acknowledge position never reads back as one.
  property p_ack_reads_zero;
    @(posedge core_clk_i) disable iff (!rstn_i) reg_rd_i |=> !reg_rdata_o[EIL_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one");

  // A status write takes the sensitivity bit.
  property p_sens_write;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == EIL_STATUS_CONTROL_OFS |=> sens_ff == $past(reg_wdata_i[EIL_SENS_BIT]);
  endproperty
  a_sens_write: assert property (p_sens_write) else $error("sensitivity write lost");

  // A status write takes the mask bit.
  property p_mask_write;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == EIL_STATUS_CONTROL_OFS |=> mask_ff == $past(reg_wdata_i[EIL_MASK_BIT]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // Status reads return the sensitivity bit as it stood at the strobe.
  property p_rd_sens;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == EIL_STATUS_CONTROL_OFS |=> reg_rdata_o[EIL_SENS_BIT] == $past(sens_ff);
  endproperty
  a_rd_sens: assert property (p_rd_sens) else $error("sensitivity readback wrong");

  // Status reads return the mask bit as it stood at the strobe.
  property p_rd_mask;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == EIL_STATUS_CONTROL_OFS |=> reg_rdata_o[EIL_MASK_BIT] == $past(mask_ff);
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask readback wrong");

  // Break control reads return the clear-enable bit.
  property p_rd_break_clear_enable;
    @(posedge core_clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == EIL_BREAK_FLAG_CTL_OFS |=> reg_rdata_o[EIL_BREAK_CLEAR_ENABLE_BIT] == $past(break_clear_enable_ff);
  endproperty
  a_rd_break_clear_enable: assert property (p_rd_break_clear_enable) else $error("break control readback wrong");

  // With clear-enable set, a software acknowledge in break does clear the latch.
  property p_break_clear;
    @(posedge core_clk_i) disable iff (!rstn_i) s_break_sw_ack |=> !latch_ff;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break ack with enable ignored");

  // The edge pulse lasts a single cycle.
  property p_fall_single;
    @(posedge core_clk_i) disable iff (!rstn_i) pin_bus.pin_fall |=> !pin_bus.pin_fall;
  endproperty
  a_fall_single: assert property (p_fall_single) else $error("edge pulse too long");

  // After reset the latch stays empty while the synchroniser refills, pin low or not.
  property p_reset_quiet;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !$past(rstn_i) |-> (!latch_ff && !sens_ff) ##1 !latch_ff [*2];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");

endmodule

/* File: eil_pin_src.sv */
// Model of the external source that pulls the active-low request pin.
// Assumes a pullup holds the pin high whenever the source lets go of it.
`timescale 1ns/1ps
module eil_pin_src
(
  // Control from the bench.
  input  wire logic       pull_low_i,
  input  wire logic [3:0] skew_i,
  // Pin.
  output logic            irq_n_o
);
  // The pin idles high through the pullup.
  initial irq_n_o = 1'b1;
  // The pin moves a few ns off the clock edge, so the synchroniser sees a truly asynchronous change.
  always @(pull_low_i)
    irq_n_o <= #(skew_i + 3) !pull_low_i;
endmodule

/* File: eil_ext_irq_tb_top.sv */
// Self-checking bench for the external interrupt latch.
// Assumes the pin source model and the design package are compiled first.
`timescale 1ns/1ps
module eil_ext_irq_tb_top import eil_pkg::*;;
  logic        core_clk_i, rstn_i, irq_n_i, reg_wr_i, reg_rd_i;
  logic        vector_fetch_i, break_state_i, ccr_int_mask_i;
  logic        cpu_irq_req_o, pin_level_o, pull_low;
  logic [1:0]  reg_addr_i, a;
  logic [7:0]  reg_wdata_i, reg_rdata_o, w;
  logic [15:0] vector_hi_addr_o, vector_lo_addr_o;
  logic [3:0]  skew;
  int          fails, tests_run, cyc;

  eil_ext_irq i_eil_ext_irq (.core_clk_i, .rstn_i, .irq_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .vector_fetch_i, .break_state_i, .ccr_int_mask_i, .cpu_irq_req_o,
    .vector_hi_addr_o, .vector_lo_addr_o, .pin_level_o);
  eil_pin_src i_eil_pin_src (.pull_low_i(pull_low), .skew_i(skew), .irq_n_o(irq_n_i));

  // Clock at 25 MHz.
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [7:0] st(input logic p, input logic m, input logic s);
    return {4'h0, p, 1'b0, m, s};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {15'h0, exp}, {15'h0, got});
  endtask

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd_chk(input logic [1:0] ad, input logic [7:0] exp, input logic [7:0] msk = 8'hFF);
    @(posedge core_clk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk("rdata", {8'h0, exp}, {8'h0, reg_rdata_o & msk});
  endtask

  // Five cycles cover the synchroniser and the latch.
  task automatic pin(input logic low);
    @(posedge core_clk_i);
    skew     <= 4'($urandom_range(15, 0));
    pull_low <= low;
    repeat (5) @(posedge core_clk_i);
  endtask

  task automatic end_of_test();
    $display("counts: tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {fails, tests_run, cyc} = '0;
    {rstn_i, pull_low, skew, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
    {vector_fetch_i, break_state_i, ccr_int_mask_i} = '0;
    void'($urandom(32'h4126144F));
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd_chk(EIL_STATUS_CONTROL_OFS, st(0, 0, 0));
    rd_chk(EIL_BREAK_FLAG_CTL_OFS, 8'h00);
    chk("vector_hi", 16'hFFFA, vector_hi_addr_o);
    chk("vector_lo", 16'hFFFB, vector_lo_addr_o);
    chk_bit("pin_level", 1'b1, pin_level_o);
    $display("test reset values done");
    pin(1'b1);
    rd_chk(0, st(1, 0, 0));
    chk_bit("req", 1'b1, cpu_irq_req_o);
    chk_bit("pin_level", 1'b0, pin_level_o);
    pin(1'b0);
    rd_chk(0, st(1, 0, 0));
    wr(0, 8'h04);
    rd_chk(0, st(0, 0, 0));
    pin(1'b1);
    rd_chk(0, st(1, 0, 0));
    @(posedge core_clk_i);
    vector_fetch_i <= 1'b1;
    @(posedge core_clk_i);
    vector_fetch_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk_bit("req", 1'b0, cpu_irq_req_o);
    pin(1'b0);
    $display("test edge mode done");
    wr(0, 8'h02);
    pin(1'b1);
    rd_chk(0, st(1, 1, 0));
    chk_bit("req", 1'b0, cpu_irq_req_o);
    wr(0, 8'h00);
    @(posedge core_clk_i);
    ccr_int_mask_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk_bit("req", 1'b0, cpu_irq_req_o);
    ccr_int_mask_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk_bit("req", 1'b1, cpu_irq_req_o);
    wr(0, 8'h04);
    pin(1'b0);
    $display("test masks done");
    wr(0, 8'h01);
    pin(1'b1);
    wr(0, 8'h03);
    #1 chk_bit("req", 1'b0, cpu_irq_req_o);
    wr(0, 8'h05);
    rd_chk(0, st(1, 0, 1));
    pin(1'b0);
    rd_chk(0, st(0, 0, 1));
    pin(1'b1);
    pin(1'b0);
    rd_chk(0, st(1, 0, 1));
    wr(0, 8'h05);
    rd_chk(0, st(0, 0, 1));
    $display("test level mode done");
    wr(0, 8'h00);
    break_state_i <= 1'b1;
    pin(1'b1);
    pin(1'b0);
    wr(0, 8'h04);
    rd_chk(0, st(1, 0, 0));
    wr(1, 8'h80);
    rd_chk(1, 8'h80);
    wr(0, 8'h04);
    break_state_i <= 1'b0;
    rd_chk(0, st(0, 0, 0));
    wr(1, 8'h00);
    $display("test break done");
    wr(0, 8'h01);
    pin(1'b1);
    rstn_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk_bit("req", 1'b0, cpu_irq_req_o);
    rstn_i <= 1'b1;
    rd_chk(0, 8'h00);
    repeat (4) @(posedge core_clk_i);
    rd_chk(0, 8'h00);
    pin(1'b0);
    wr(0, 8'h04);
    $display("test mid reset done");
    // Random writes stay clear of a pending request, so the status readback is fully predictable.
    repeat (8)
    begin
      w = 8'($urandom);
      a = 2'($urandom_range(3, 2));
      wr(a, w);
      rd_chk(a, 8'h00);
      wr(0, w);
      rd_chk(0, st(0, w[1], w[0]));
    end
    $display("test random registers done");
    end_of_test();
  end
endmodule
